// ===== rtl/lsw_pkg.sv
// Purpose: shared constants for the link status word encoder
// Assumes: one core clock, synchronous active-high reset
// Notes: register offsets are byte addresses on a 32-bit classic Wishbone
package lsw_pkg;
	localparam int unsigned LSW_WORD_W = 32;
	localparam logic [31:0] LSW_WORD_RST = 32'h0000_0000;
	// status word fields
	localparam int unsigned LSW_BIT_LINK = 0;
	localparam int unsigned LSW_SPD_LO = 1;
	localparam int unsigned LSW_SPD_HI = 4;
	localparam int unsigned LSW_BIT_AN_EN = 5;
	localparam int unsigned LSW_BIT_AN_DONE = 6;
	localparam int unsigned LSW_EXT_LO = 24;
	localparam int unsigned LSW_RESP_BYTE_FIRST = 20;
	localparam int unsigned LSW_RESP_BYTE_LAST = 23;
	// speed and duplex codes
	localparam logic [3:0] LSW_SD_NONE = 4'h0;
	localparam logic [3:0] LSW_SD_10H = 4'h1;
	localparam logic [3:0] LSW_SD_10F = 4'h2;
	localparam logic [3:0] LSW_SD_100H = 4'h3;
	localparam logic [3:0] LSW_SD_100H4 = 4'h4;
	localparam logic [3:0] LSW_SD_100F = 4'h5;
	localparam logic [3:0] LSW_SD_1GH = 4'h6;
	localparam logic [3:0] LSW_SD_1GF = 4'h7;
	localparam logic [3:0] LSW_SD_10G = 4'h8;
	localparam logic [3:0] LSW_SD_20G = 4'h9;
	localparam logic [3:0] LSW_SD_25G = 4'ha;
	localparam logic [3:0] LSW_SD_40G = 4'hb;
	localparam logic [3:0] LSW_SD_50G = 4'hc;
	localparam logic [3:0] LSW_SD_100G = 4'hd;
	localparam logic [3:0] LSW_SD_2G5 = 4'he;
	localparam logic [3:0] LSW_SD_EXT = 4'hf;
	// register map
	localparam logic [3:0] LSW_REG_CTRL = 4'h0;
	localparam logic [3:0] LSW_REG_WORD = 4'h4;
	localparam logic [3:0] LSW_REG_IRQ_STAT = 4'h8;
	localparam logic [3:0] LSW_REG_IRQ_MASK = 4'hc;
	localparam int unsigned LSW_CTRL_EXT_EN = 0;
	localparam int unsigned LSW_CTRL_FORCE_EN = 1;
	localparam logic [1:0] LSW_CTRL_RST = 2'h0;
	localparam logic [2:0] LSW_IRQ_RST = 3'h0;
	// interrupt status bits
	localparam int unsigned LSW_IRQ_LINK = 0;
	localparam int unsigned LSW_IRQ_SPEED = 1;
	localparam int unsigned LSW_IRQ_AN_DONE = 2;
endpackage : lsw_pkg

// ===== rtl/lsw_speed_code.sv
// Purpose: maps link rate and duplex to the 4-bit speed-duplex code
// Assumes: inputs already resolved by the link state logic
// Notes: purely combinational
`timescale 1ns/1ps
module lsw_speed_code (
	input wire logic [3:0] rate_i,
	input wire logic full_duplex_i,
	input wire logic t4_i,
	input wire logic ext_rates_en_i,
	output logic [3:0] code_o
);
	// rate_i: 0 none,1 10M,2 100M,3 1G,4 10G,5 20G,6 25G,7 40G,8 50G,9 100G,10 2.5G,15 ext
	always_comb begin
		code_o = lsw_pkg::LSW_SD_NONE;
		case (rate_i)
			4'h1: code_o = full_duplex_i ? lsw_pkg::LSW_SD_10F : lsw_pkg::LSW_SD_10H;
			4'h2: begin
				if (full_duplex_i) begin
					code_o = lsw_pkg::LSW_SD_100F;
				end else begin
					code_o = t4_i ? lsw_pkg::LSW_SD_100H4 : lsw_pkg::LSW_SD_100H;
				end
			end
			4'h3: code_o = full_duplex_i ? lsw_pkg::LSW_SD_1GF : lsw_pkg::LSW_SD_1GH;
			4'h4: code_o = lsw_pkg::LSW_SD_10G;
			// newer rates fall back to the nearest older code when disabled
			4'h5: code_o = ext_rates_en_i ? lsw_pkg::LSW_SD_20G : lsw_pkg::LSW_SD_10G;
			4'h6: code_o = ext_rates_en_i ? lsw_pkg::LSW_SD_25G : lsw_pkg::LSW_SD_10G;
			4'h7: code_o = ext_rates_en_i ? lsw_pkg::LSW_SD_40G : lsw_pkg::LSW_SD_10G;
			4'h8: code_o = ext_rates_en_i ? lsw_pkg::LSW_SD_50G : lsw_pkg::LSW_SD_10G;
			4'h9: code_o = ext_rates_en_i ? lsw_pkg::LSW_SD_100G : lsw_pkg::LSW_SD_10G;
			4'ha: code_o = ext_rates_en_i ? lsw_pkg::LSW_SD_2G5 : lsw_pkg::LSW_SD_1GF;
			4'hf: code_o = ext_rates_en_i ? lsw_pkg::LSW_SD_EXT : lsw_pkg::LSW_SD_10G;
			default: code_o = lsw_pkg::LSW_SD_NONE;
		endcase
	end
endmodule : lsw_speed_code

// ===== rtl/lsw_encoder.sv
// Purpose: builds the link status word for the query response
// Assumes: link inputs are asynchronous pins, bus is classic Wishbone
// Notes: bits 31:7 other than the extended field are left zero
//
// Functional notes
// - bit 0 is link up, including low power idle
// - code zero unless negotiation done and valid, or forced setting selected by LSW_CTRL_FORCE_EN
// - copper codes one through seven
// - code eight means 10 Gb
// - codes nine to fourteen optional newer rates
// - code fifteen defers to field at bit 24
// - forced setting reportable while serializer flag clear
// - unlisted mode reports nearest listed code
// - bit 5 set when negotiation enabled
// - bit 5 zero if unsupported, disabled, non-Ethernet
// - bit 6 set when negotiation finished
// - bit 6 gated likewise, parallel detect counts
// - word goes in response bytes 20 to 23
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module lsw_encoder #(
	parameter bit AN_SUPPORTED = 1'b1,
	parameter int unsigned EXT_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic link_up_i,
	input wire logic lpi_i,
	input wire logic is_ethernet_i,
	input wire logic serializer_path_flag_i,
	input wire logic an_enabled_i,
	input wire logic an_done_i,
	input wire logic parallel_detect_i,
	input wire logic highest_common_mode_valid_i,
	input wire logic [3:0] highest_common_mode_i,
	input wire logic hcm_full_duplex_i,
	input wire logic hcm_t4_i,
	input wire logic [3:0] forced_rate_i,
	input wire logic forced_full_duplex_i,
	input wire logic [EXT_W-1:0] ext_speed_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	output logic [31:0] status_word_o,
	output logic [7:0] resp_byte_o
);
	localparam int unsigned NIN = 18 + EXT_W;

	// two-flop synchroniser for all link-side pins
	logic [NIN-1:0] pins_raw, sync1_q, sync2_q;
	assign pins_raw = {ext_speed_i, forced_full_duplex_i, forced_rate_i, hcm_t4_i,
		hcm_full_duplex_i, highest_common_mode_i, highest_common_mode_valid_i,
		parallel_detect_i, an_done_i, an_enabled_i, serializer_path_flag_i,
		is_ethernet_i, link_up_i | lpi_i};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else if (ce_i) begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
		end
	end

	logic s_link, s_eth, s_serdes, s_an_en, s_an_done, s_pd, s_hcm_ok;
	logic [3:0] s_hcm, s_frate;
	logic s_hfd, s_ht4, s_ffd;
	logic [EXT_W-1:0] s_ext;
	assign s_link = sync2_q[0];
	assign s_eth = sync2_q[1];
	assign s_serdes = sync2_q[2];
	assign s_an_en = sync2_q[3];
	assign s_an_done = sync2_q[4];
	assign s_pd = sync2_q[5];
	assign s_hcm_ok = sync2_q[6];
	assign s_hcm = sync2_q[10:7];
	assign s_hfd = sync2_q[11];
	assign s_ht4 = sync2_q[12];
	assign s_frate = sync2_q[16:13];
	assign s_ffd = sync2_q[17];
	assign s_ext = sync2_q[NIN-1:18];

	// control and interrupt registers, bus request decode
	logic [1:0] ctrl_q;
	logic [2:0] irq_stat_q, irq_mask_q;
	logic bus_req, wr_req;
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_req = bus_req & wb_we_i & wb_sel_i[0];

	logic an_on, an_fin, forced_path, use_neg;
	assign an_on = AN_SUPPORTED & s_an_en & s_eth;
	// parallel detection still counts as a finished negotiation
	assign an_fin = an_on & (s_an_done | s_pd);
	assign forced_path = ~s_an_en & ~s_serdes & ctrl_q[lsw_pkg::LSW_CTRL_FORCE_EN];
	assign use_neg = an_fin & ~s_serdes & s_hcm_ok;

	logic [3:0] rate_sel;
	logic fd_sel, t4_sel;
	logic [3:0] sd_code;
	always_comb begin
		rate_sel = 4'h0;
		fd_sel = 1'b0;
		t4_sel = 1'b0;
		if (use_neg) begin
			rate_sel = s_hcm;
			fd_sel = s_hfd;
			t4_sel = s_ht4;
		end else if (forced_path) begin
			rate_sel = s_frate;
			fd_sel = s_ffd;
		end
	end

	lsw_speed_code u_code (
		.rate_i(rate_sel),
		.full_duplex_i(fd_sel),
		.t4_i(t4_sel),
		.ext_rates_en_i(ctrl_q[lsw_pkg::LSW_CTRL_EXT_EN]),
		.code_o(sd_code)
	);

	logic [31:0] word_d, word_q;
	always_comb begin
		word_d = '0;
		word_d[lsw_pkg::LSW_BIT_LINK] = s_link;
		word_d[lsw_pkg::LSW_SPD_HI:lsw_pkg::LSW_SPD_LO] = sd_code;
		word_d[lsw_pkg::LSW_BIT_AN_EN] = an_on;
		word_d[lsw_pkg::LSW_BIT_AN_DONE] = an_fin;
		if (sd_code == lsw_pkg::LSW_SD_EXT) begin
			word_d[lsw_pkg::LSW_EXT_LO +: EXT_W] = s_ext;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			word_q <= lsw_pkg::LSW_WORD_RST;
		end else if (ce_i) begin
			word_q <= word_d;
		end
	end
	assign status_word_o = word_q;

	// response byte index 0..3 selects bytes 20..23, most significant first
	logic [1:0] byte_idx_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			byte_idx_q <= 2'h0;
			resp_byte_o <= 8'h00;
		end else if (ce_i) begin
			byte_idx_q <= byte_idx_q + 2'h1;
			case (byte_idx_q)
				2'h0: resp_byte_o <= word_q[31:24];
				2'h1: resp_byte_o <= word_q[23:16];
				2'h2: resp_byte_o <= word_q[15:8];
				default: resp_byte_o <= word_q[7:0];
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= lsw_pkg::LSW_CTRL_RST;
		end else if (ce_i && wr_req && wb_adr_i == lsw_pkg::LSW_REG_CTRL) begin
			ctrl_q <= wb_dat_i[1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask_q <= lsw_pkg::LSW_IRQ_RST;
		end else if (ce_i && wr_req && wb_adr_i == lsw_pkg::LSW_REG_IRQ_MASK) begin
			irq_mask_q <= wb_dat_i[2:0];
		end
	end

	// events: link change, speed code change, negotiation finishing
	logic [2:0] ev;
	assign ev[lsw_pkg::LSW_IRQ_LINK] = word_d[0] ^ word_q[0];
	assign ev[lsw_pkg::LSW_IRQ_SPEED] = word_d[4:1] != word_q[4:1];
	assign ev[lsw_pkg::LSW_IRQ_AN_DONE] = word_d[6] & ~word_q[6];

	logic [2:0] clr;
	assign clr = (wr_req && wb_adr_i == lsw_pkg::LSW_REG_IRQ_STAT) ? wb_dat_i[2:0] : 3'h0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= lsw_pkg::LSW_IRQ_RST;
		end else if (ce_i) begin
			// set wins over a simultaneous clear
			irq_stat_q <= (irq_stat_q & ~clr) | ev;
		end
	end
	assign irq_o = |(irq_stat_q & irq_mask_q);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
					lsw_pkg::LSW_REG_CTRL: wb_dat_o <= {30'h0, ctrl_q};
					lsw_pkg::LSW_REG_WORD: wb_dat_o <= word_q;
					lsw_pkg::LSW_REG_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat_q};
					lsw_pkg::LSW_REG_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask_q};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule : lsw_encoder

// ===== dv/lsw_encoder_properties.sv
// Purpose: port checks for the link status word encoder
// Assumes: ce_i held high, AN_SUPPORTED left at one
// Notes: pin checks wait out the three-edge pipe after each reset
`timescale 1ns/1ps
module lsw_encoder_properties (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic link_up_i,
	input wire logic lpi_i,
	input wire logic is_ethernet_i,
	input wire logic serializer_path_flag_i,
	input wire logic an_enabled_i,
	input wire logic an_done_i,
	input wire logic parallel_detect_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] status_word_o
);
	logic [2:0] up_q;
	logic ok, lk, an_ok, dn, pend;
	assign ok = up_q[2];
	assign lk = link_up_i | lpi_i;
	assign an_ok = an_enabled_i & is_ethernet_i;
	assign dn = an_ok & (an_done_i | parallel_detect_i);
	assign pend = an_ok & ~an_done_i & ~parallel_detect_i;
	// pre-reset pin samples must not reach the checks
	always_ff @(posedge clk_i) begin
		if (rst_i) up_q <= 3'h0;
		else if (!ok) up_q <= up_q + 3'h1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_link_flag: assert property (ok |-> status_word_o[0] == $past(lk, 3))
		else $error("link bit wrong");
	a_serdes_zero: assert property (ok && $past(serializer_path_flag_i, 3)
		|-> status_word_o[4:1] == 4'h0) else $error("code not zero on serializer path");
	a_pend_zero: assert property (ok && $past(pend, 3) |-> status_word_o[4:1] == 4'h0)
		else $error("code not zero while negotiating");
	a_an_flag: assert property (ok |-> status_word_o[5] == $past(an_ok, 3))
		else $error("negotiation enable bit wrong");
	a_an_done: assert property (ok |-> status_word_o[6] == $past(dn, 3))
		else $error("negotiation done bit wrong");
	a_ext_gate: assert property (status_word_o[4:1] != 4'hf |-> status_word_o[31:24] == 8'h0)
		else $error("extended field set without code f");
	a_reset_clear: assert property (disable iff (1'b0) rst_i |=> status_word_o == 32'h0)
		else $error("word not cleared by reset");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus not answered in one cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	c_lpi: cover property (ok && lpi_i && !link_up_i);
	c_code7: cover property (status_word_o[4:1] == 4'h7);
	c_ext: cover property (status_word_o[4:1] == 4'hf);
endmodule : lsw_encoder_properties
bind lsw_encoder lsw_encoder_properties u_props (.clk_i, .rst_i, .link_up_i, .lpi_i,
	.is_ethernet_i, .serializer_path_flag_i, .an_enabled_i, .an_done_i, .parallel_detect_i,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .status_word_o);

// ===== dv/lsw_mc_model.sv
// Purpose: management side collecting response bytes of the status word
// Assumes: bytes arrive most significant first, one per clock
// Notes: keeps only the last four bytes, no framing
`timescale 1ns/1ps
module lsw_mc_model (
	input wire logic clk_i,
	input wire logic [7:0] byte_i,
	output logic [31:0] word_o
);
	always_ff @(posedge clk_i) begin
		word_o <= {word_o[23:0], byte_i};
	end
endmodule : lsw_mc_model

// ===== dv/tb.sv
// Purpose: directed bench for the link status word encoder
// Assumes: bus answers one cycle after take
// Notes: ce_i held high, so the freeze path goes unexercised
`timescale 1ns/1ps
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] pins = 8'h0;
	logic [3:0] rate = 4'h0, adr = 4'h0, sel = 4'h0;
	logic fd = 1'b0, t4 = 1'b0, we = 1'b0, cyc = 1'b0, hit = 1'b0, ack, irq;
	logic [31:0] wdat = 32'h0, rdat, sw, mw, q;
	logic [7:0] rb;
	int n_errors = 0, check_count = 0, cycles = 0;
	logic [3:0] ra [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
	logic [11:0] tab [17] = '{12'h081, 12'h0c2, 12'h103, 12'h124, 12'h145, 12'h186,
		12'h1c7, 12'h248, 12'h3c8, 12'h547, 12'hac9, 12'hb4a, 12'hbcb, 12'hc4c, 12'hccd,
		12'hd4e, 12'hfcf};
	logic [9:0] pv [7] = '{10'h0b5, 10'h0f6, 10'h0a6, 10'h0ae, 10'h0b2, 10'h03e, 10'h286};
	logic [6:0] ev [7] = '{7'h6f, 7'h61, 7'h21, 7'h6f, 7'h61, 7'h01, 7'h07};
	always #5 clk_i = ~clk_i;
	lsw_encoder u_dut (.clk_i, .rst_i, .ce_i(1'b1), .link_up_i(pins[1]), .lpi_i(pins[0]),
		.is_ethernet_i(pins[7]), .serializer_path_flag_i(pins[6]), .an_enabled_i(pins[5]),
		.an_done_i(pins[4]), .parallel_detect_i(pins[3]),
		.highest_common_mode_valid_i(pins[2]), .highest_common_mode_i(rate),
		.hcm_full_duplex_i(fd), .hcm_t4_i(t4), .forced_rate_i(4'h2),
		.forced_full_duplex_i(1'b0), .ext_speed_i(8'h5a), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq_o(irq), .status_word_o(sw), .resp_byte_o(rb));
	lsw_mc_model u_mc (.clk_i, .byte_i(rb), .word_o(mw));
	task automatic stop_test;
		if (n_errors == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic apply(input logic [9:0] p, input logic [3:0] r, input logic f,
		input logic t, input logic [31:0] exp);
		bus(1'b1, 4'h0, 4'hf, {30'h0, p[9:8]});
		pins <= p[7:0];
		rate <= r;
		fd <= f;
		t4 <= t;
		repeat (5) @(posedge clk_i);
		bus(1'b0, 4'h4, 4'hf, 32'h0);
		chk(q, exp);
		chk(sw, exp);
	endtask : apply
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			stop_test();
		end
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b1, 4'h2, 4'hf, 32'hffffffff);
		bus(1'b1, 4'h0, 4'he, 32'h3);
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 4'hf, 32'h0);
			chk(q, 32'h0);
		end
		foreach (tab[i]) apply({1'b0, tab[i][11], 8'hb6}, tab[i][10:7], tab[i][6], tab[i][5],
			{tab[i][3:0] == 4'hf ? 8'h5a : 8'h0, 17'h0, 2'b11, tab[i][3:0], 1'b1});
		foreach (pv[i]) apply(pv[i], 4'h3, 1'b1, 1'b0,
			{25'h0, ev[i]});
		repeat (4) begin
			@(posedge clk_i);
			hit = hit | (mw === 32'h7);
		end
		chk({31'h0, hit}, 32'h1);
		bus(1'b1, 4'h8, 4'hf, 32'h7);
		pins <= 8'h84;
		repeat (5) @(posedge clk_i);
		bus(1'b0, 4'h8, 4'hf, 32'h0);
		chk(q, 32'h1);
		// mask bits enable: a set status bit stays silent until its mask bit is one
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 4'hc, 4'hf, 32'h7);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, 4'hc, 4'hf, 32'h0);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 4'hc, 4'hf, 32'h7);
		bus(1'b1, 4'h8, 4'hf, 32'h7);
		bus(1'b0, 4'h8, 4'hf, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, irq}, 32'h0);
		stop_test();
	end
endmodule : tb
